// >>> battery_fault_response.v
// Our own choices: the register offsets and register access over AXI4-Lite.
`include "bfr_defines.vh"
// fault response for codes 11 to 17 with an AXI4-Lite register port
// assumes pin inputs are asynchronous; current is signed, positive while charging
module battery_fault_response #(
	parameter CUR_W = 16,
	parameter [63:0] PAUSE_CYCLES = `BFR_PAUSE_CYC
) (
	// clock, reset, enable
	input wire i_core_clk,
	input wire i_rst_b,
	input wire i_ce,
	// measurement and system state pins
	input wire [CUR_W-1:0] i_current,
	input wire i_contactor_open_cmd,
	input wire i_cell_chemistry_select_valid,
	input wire i_nvm_interrupted,
	input wire i_fuse_blown,
	input wire i_balance_fail,
	input wire i_selfcheck_done,
	input wire i_i2c_fail,
	input wire i_spi_fail,
	// pack and inverter outputs
	output reg o_charge_en,
	output reg o_discharge_en,
	output reg o_opto_relay_on,
	output reg o_charge_opto_en,
	output reg o_normal_run,
	output reg o_load_defaults,
	output reg [CUR_W-1:0] o_chg_limit_rep,
	output reg [CUR_W-1:0] o_dsg_limit_rep,
	output reg [4:0] o_fault_code,
	output reg o_irq,
	// axi4-lite write address
	input wire i_awvalid,
	output reg o_awready,
	input wire [`BFR_ADDR_W-1:0] i_awaddr,
	// axi4-lite write data
	input wire i_wvalid,
	output reg o_wready,
	input wire [31:0] i_wdata,
	input wire [3:0] i_wstrb,
	// axi4-lite write response
	output reg o_bvalid,
	input wire i_bready,
	output reg [1:0] o_bresp,
	// axi4-lite read address
	input wire i_arvalid,
	output reg o_arready,
	input wire [`BFR_ADDR_W-1:0] i_araddr,
	// axi4-lite read data
	output reg o_rvalid,
	input wire i_rready,
	output reg [31:0] o_rdata,
	output reg [1:0] o_rresp
);
	localparam NF = `BFR_NFAULT;
	localparam PW = 8;

	// byte-lane merge for register writes
	function [31:0] merge;
		input [31:0] old;
		input [31:0] wd;
		input [3:0] st;
		integer b;
		begin
			merge = old;
			for (b = 0; b < 4; b = b + 1)
				if (st[b])
					merge[b*8 +: 8] = wd[b*8 +: 8];
		end
	endfunction

	// magnitude above 1.2 times limit, in integer form 5*mag > 6*lim
	function over_scaled;
		input [CUR_W:0] mag;
		input [CUR_W-1:0] lim;
		reg [CUR_W+4:0] lhs;
		reg [CUR_W+4:0] rhs;
		begin
			lhs = {4'h0, mag} * `BFR_OVER_DEN;
			rhs = {5'h00, lim} * `BFR_OVER_NUM;
			over_scaled = lhs > rhs;
		end
	endfunction

	// ---------------- pin synchronisers ----------------
	wire [CUR_W-1:0] cur_s;
	wire [PW-1:0] pin_s;
	bfr_sync #(.W(CUR_W)) u_cur_sync (
		.i_core_clk(i_core_clk),
		.i_rst_b(i_rst_b),
		.i_ce(i_ce),
		.i_async(i_current),
		.o_sync(cur_s)
	);
	bfr_sync #(.W(PW)) u_pin_sync (
		.i_core_clk(i_core_clk),
		.i_rst_b(i_rst_b),
		.i_ce(i_ce),
		.i_async({i_contactor_open_cmd, i_cell_chemistry_select_valid, i_nvm_interrupted, i_fuse_blown,
			i_balance_fail, i_selfcheck_done, i_i2c_fail, i_spi_fail}),
		.o_sync(pin_s)
	);
	wire open_cmd = pin_s[7];
	wire cell_chemistry_select_ok = pin_s[6];
	wire nvm_int = pin_s[5];
	wire fuse_bad = pin_s[4];
	wire bal_bad = pin_s[3];
	wire chk_done = pin_s[2];
	wire link_bad = pin_s[1] | pin_s[0];

	// ---------------- configuration registers ----------------
	reg [1:0] ctrl_q;
	reg [NF-1:0] status_q;
	reg [NF-1:0] mask_q;
	reg [CUR_W-1:0] chg_trip_q;
	reg [CUR_W-1:0] dsg_trip_q;
	reg [CUR_W-1:0] chg_lim_q;
	reg [CUR_W-1:0] dsg_lim_q;
	reg [CUR_W-1:0] shunt_max_q;

	// ---------------- current magnitudes ----------------
	wire cur_neg = cur_s[CUR_W-1];
	wire cur_pos = ~cur_neg & (|cur_s);
	wire [CUR_W:0] chg_mag = cur_pos ? {1'b0, cur_s} : {(CUR_W+1){1'b0}};
	wire [CUR_W:0] dsg_mag = cur_neg ? ({1'b0, ~cur_s} + 1'b1) : {(CUR_W+1){1'b0}};
	wire [CUR_W:0] shunt2 = {shunt_max_q, 1'b0};

	// ---------------- fault conditions ----------------
	// start-up self-check result is captured once and held
	reg chk_seen_q;
	reg f15_q;
	reg nvm_q;
	wire [NF-1:0] cond;
	assign cond[`BFR_F11] = open_cmd & (|cur_s); // RULE_01
	assign cond[`BFR_F12] = ~ctrl_q[`BFR_CTRL_MEAS_EN]
		| (chg_mag > shunt2) | (dsg_mag > shunt2)
		| (chg_mag > {1'b0, chg_trip_q}) | (dsg_mag > {1'b0, dsg_trip_q}); // RULE_02
	assign cond[`BFR_F13] = ctrl_q[`BFR_CTRL_CELL_CHEMISTRY_SELECT_REQ] & ~cell_chemistry_select_ok; // RULE_04
	assign cond[`BFR_F14] = nvm_int; // RULE_05
	assign cond[`BFR_F15] = f15_q; // RULE_06
	assign cond[`BFR_F16] = link_bad; // RULE_07
	assign cond[`BFR_F17] = over_scaled(chg_mag, chg_lim_q)
		| over_scaled(dsg_mag, dsg_lim_q); // RULE_08

	always @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			chk_seen_q <= 1'b0;
			f15_q <= 1'b0;
			nvm_q <= 1'b0;
		end else if (i_ce) begin
			nvm_q <= nvm_int;
			if (chk_done & ~chk_seen_q) begin
				chk_seen_q <= 1'b1;
				f15_q <= fuse_bad | bal_bad; // RULE_06
			end
		end
	end

	// ---------------- reconnection pause ----------------
	wire pause_busy;
	bfr_pause #(.PAUSE_CYCLES(PAUSE_CYCLES)) u_pause (
		.i_core_clk(i_core_clk),
		.i_rst_b(i_rst_b),
		.i_ce(i_ce),
		.i_hold(cond[`BFR_F12]),
		.o_busy(pause_busy) // RULE_03
	);

	// ---------------- fault response ----------------
	wire block_all = cond[`BFR_F11] | cond[`BFR_F12] | pause_busy | cond[`BFR_F13]
		| cond[`BFR_F15] | cond[`BFR_F16];
	reg [4:0] code_d;
	always @* begin
		code_d = `BFR_CODE_NONE;
		if (cond[`BFR_F11])
			code_d = `BFR_CODE_11;
		else if (cond[`BFR_F12])
			code_d = `BFR_CODE_12;
		else if (cond[`BFR_F13])
			code_d = `BFR_CODE_13;
		else if (cond[`BFR_F15])
			code_d = `BFR_CODE_15;
		else if (cond[`BFR_F16])
			code_d = `BFR_CODE_16;
		else if (cond[`BFR_F17])
			code_d = `BFR_CODE_17;
		else if (cond[`BFR_F14])
			code_d = `BFR_CODE_14;
	end

	always @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			o_charge_en <= 1'b0;
			o_discharge_en <= 1'b0;
			o_opto_relay_on <= 1'b0;
			o_charge_opto_en <= 1'b0;
			o_normal_run <= 1'b0;
			o_load_defaults <= 1'b0;
			o_chg_limit_rep <= {CUR_W{1'b0}};
			o_dsg_limit_rep <= {CUR_W{1'b0}};
			o_fault_code <= `BFR_CODE_NONE;
		end else if (i_ce) begin
			o_charge_en <= ~block_all; // RULE_01 RULE_03 RULE_04 RULE_06 RULE_07
			o_discharge_en <= ~block_all; // RULE_01 RULE_03 RULE_04 RULE_06 RULE_07
			o_opto_relay_on <= ~block_all; // RULE_01 RULE_03 RULE_06 RULE_07 RULE_08
			o_charge_opto_en <= ~cond[`BFR_F13]; // RULE_04
			o_normal_run <= ~cond[`BFR_F16]; // RULE_07
			o_load_defaults <= nvm_int & ~nvm_q; // RULE_05
			// halve the reported limits while overcurrent persists
			o_chg_limit_rep <= cond[`BFR_F17] ? {1'b0, chg_lim_q[CUR_W-1:1]} : chg_lim_q; // RULE_08
			o_dsg_limit_rep <= cond[`BFR_F17] ? {1'b0, dsg_lim_q[CUR_W-1:1]} : dsg_lim_q; // RULE_08
			o_fault_code <= code_d; // RULE_09
		end
	end

	// ---------------- axi4-lite write path ----------------
	reg aw_have_q;
	reg w_have_q;
	reg [`BFR_ADDR_W-1:0] waddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	wire do_write = aw_have_q & w_have_q & ~o_bvalid;
	wire wr_status = do_write & (waddr_q == `BFR_REG_STATUS);
	wire [31:0] status_clr = wr_status ? merge(32'h00000000, wdata_q, wstrb_q) : 32'h00000000;

	always @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			waddr_q <= {`BFR_ADDR_W{1'b0}};
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			o_awready <= 1'b0;
			o_wready <= 1'b0;
			o_bvalid <= 1'b0;
			o_bresp <= `BFR_RESP_OKAY;
		end else if (i_ce) begin
			o_awready <= ~aw_have_q & ~o_awready & ~(i_awvalid & o_awready);
			o_wready <= ~w_have_q & ~o_wready & ~(i_wvalid & o_wready);
			if (i_awvalid & o_awready) begin
				aw_have_q <= 1'b1;
				waddr_q <= i_awaddr;
				o_awready <= 1'b0;
			end
			if (i_wvalid & o_wready) begin
				w_have_q <= 1'b1;
				wdata_q <= i_wdata;
				wstrb_q <= i_wstrb;
				o_wready <= 1'b0;
			end
			if (do_write) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				o_bvalid <= 1'b1;
				case (waddr_q)
					`BFR_REG_CTRL, `BFR_REG_STATUS, `BFR_REG_MASK, `BFR_REG_FAULT,
					`BFR_REG_CHG_TRIP, `BFR_REG_DSG_TRIP, `BFR_REG_CHG_LIM,
					`BFR_REG_DSG_LIM, `BFR_REG_SHUNT_MAX: o_bresp <= `BFR_RESP_OKAY;
					default: o_bresp <= `BFR_RESP_SLVERR;
				endcase
			end else if (o_bvalid & i_bready)
				o_bvalid <= 1'b0;
		end
	end

	// current value of the addressed register, for byte-lane merging
	reg [31:0] wr_old;
	always @* begin
		case (waddr_q)
			`BFR_REG_CTRL: wr_old = {30'h0, ctrl_q};
			`BFR_REG_MASK: wr_old = {25'h0, mask_q};
			`BFR_REG_CHG_TRIP: wr_old = {16'h0, chg_trip_q};
			`BFR_REG_DSG_TRIP: wr_old = {16'h0, dsg_trip_q};
			`BFR_REG_CHG_LIM: wr_old = {16'h0, chg_lim_q};
			`BFR_REG_DSG_LIM: wr_old = {16'h0, dsg_lim_q};
			`BFR_REG_SHUNT_MAX: wr_old = {16'h0, shunt_max_q};
			default: wr_old = 32'h00000000;
		endcase
	end
	wire [31:0] wr_new = merge(wr_old, wdata_q, wstrb_q);

	// register storage; a new event wins over a write-one clear
	always @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			ctrl_q <= `BFR_CTRL_RST;
			status_q <= {NF{1'b0}};
			mask_q <= `BFR_MASK_RST;
			chg_trip_q <= `BFR_LIM_RST;
			dsg_trip_q <= `BFR_LIM_RST;
			chg_lim_q <= `BFR_LIM_RST;
			dsg_lim_q <= `BFR_LIM_RST;
			shunt_max_q <= `BFR_LIM_RST;
			o_irq <= 1'b0;
		end else if (i_ce) begin
			status_q <= (status_q & ~status_clr[NF-1:0]) | cond;
			o_irq <= |(status_q & mask_q);
			if (do_write) begin
				case (waddr_q)
					`BFR_REG_CTRL: ctrl_q <= wr_new[1:0];
					`BFR_REG_MASK: mask_q <= wr_new[NF-1:0];
					`BFR_REG_CHG_TRIP: chg_trip_q <= wr_new[CUR_W-1:0];
					`BFR_REG_DSG_TRIP: dsg_trip_q <= wr_new[CUR_W-1:0];
					`BFR_REG_CHG_LIM: chg_lim_q <= wr_new[CUR_W-1:0];
					`BFR_REG_DSG_LIM: dsg_lim_q <= wr_new[CUR_W-1:0];
					`BFR_REG_SHUNT_MAX: shunt_max_q <= wr_new[CUR_W-1:0];
					default: ;
				endcase
			end
		end
	end

	// ---------------- axi4-lite read path ----------------
	reg [31:0] rd_d;
	reg rd_ok;
	always @* begin
		rd_d = 32'h00000000;
		rd_ok = 1'b1;
		case (i_araddr)
			`BFR_REG_CTRL: rd_d = {30'h0, ctrl_q};
			`BFR_REG_STATUS: rd_d = {25'h0, status_q};
			`BFR_REG_MASK: rd_d = {25'h0, mask_q};
			`BFR_REG_FAULT: rd_d = {13'h0000, cond, 3'h0, pause_busy, 3'h0, o_fault_code};
			`BFR_REG_CHG_TRIP: rd_d = {16'h0, chg_trip_q};
			`BFR_REG_DSG_TRIP: rd_d = {16'h0, dsg_trip_q};
			`BFR_REG_CHG_LIM: rd_d = {16'h0, chg_lim_q};
			`BFR_REG_DSG_LIM: rd_d = {16'h0, dsg_lim_q};
			`BFR_REG_SHUNT_MAX: rd_d = {16'h0, shunt_max_q};
			default: rd_ok = 1'b0;
		endcase
	end

	always @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			o_arready <= 1'b0;
			o_rvalid <= 1'b0;
			o_rdata <= 32'h00000000;
			o_rresp <= `BFR_RESP_OKAY;
		end else if (i_ce) begin
			o_arready <= ~o_rvalid & ~o_arready;
			if (i_arvalid & o_arready) begin
				o_arready <= 1'b0;
				o_rvalid <= 1'b1;
				o_rdata <= rd_d;
				o_rresp <= rd_ok ? `BFR_RESP_OKAY : `BFR_RESP_SLVERR;
			end else if (o_rvalid & i_rready)
				o_rvalid <= 1'b0;
		end
	end
endmodule

// >>> bfr_defines.vh
// constants for the battery fault response block: register map, fields, fault codes, timing
// assumes a 250 MHz core clock and a 32-bit AXI4-Lite register port
// Contract
// [RULE_01] contactor commanded open with nonzero current: fault 11, block charge, discharge, relay
// [RULE_02] fault 12 on measurement off, current above twice shunt max or trip limits
// [RULE_03] fault 12 blocks charge, discharge, relay, then 15 s pause before reconnection
// [RULE_04] bad or missing chemistry where mandatory: fault 13, block all, disable charge opto
// [RULE_05] interrupted settings access: fault 14, load defaults, keep everything enabled
// [RULE_06] start-up blown fuse or balancing failure: fault 15, block all, open relay
// [RULE_07] internal serial link failure: fault 16, no normal operation, block all, open relay
// [RULE_08] current above 1.2 times limits: fault 17, reduce reported limits, relay stays
// [RULE_09] active fault code is shown as status while its condition persists
`ifndef BFR_DEFINES_VH
`define BFR_DEFINES_VH

`define BFR_ADDR_W 8
`define BFR_REG_CTRL 8'h00
`define BFR_REG_STATUS 8'h04
`define BFR_REG_MASK 8'h08
`define BFR_REG_FAULT 8'h0C
`define BFR_REG_CHG_TRIP 8'h10
`define BFR_REG_DSG_TRIP 8'h14
`define BFR_REG_CHG_LIM 8'h18
`define BFR_REG_DSG_LIM 8'h1C
`define BFR_REG_SHUNT_MAX 8'h20

`define BFR_CTRL_MEAS_EN 0
`define BFR_CTRL_CELL_CHEMISTRY_SELECT_REQ 1
`define BFR_CTRL_RST 2'h1
`define BFR_LIM_RST 16'hFFFF
`define BFR_MASK_RST 7'h00

`define BFR_F11 0
`define BFR_F12 1
`define BFR_F13 2
`define BFR_F14 3
`define BFR_F15 4
`define BFR_F16 5
`define BFR_F17 6
`define BFR_NFAULT 7

`define BFR_CODE_NONE 5'h00
`define BFR_CODE_11 5'h0B
`define BFR_CODE_12 5'h0C
`define BFR_CODE_13 5'h0D
`define BFR_CODE_14 5'h0E
`define BFR_CODE_15 5'h0F
`define BFR_CODE_16 5'h10
`define BFR_CODE_17 5'h11

`define BFR_CLK_HZ 64'd250000000
`define BFR_PAUSE_S 64'd15
`define BFR_PAUSE_CYC (`BFR_PAUSE_S * `BFR_CLK_HZ)
`define BFR_OVER_NUM 20'h00006
`define BFR_OVER_DEN 20'h00005
`define BFR_RESP_OKAY 2'h0
`define BFR_RESP_SLVERR 2'h2

`endif

// >>> bfr_sync.v
// two flip-flop synchroniser for a group of independent level inputs
// assumes each bit changes slowly compared with the core clock
module bfr_sync #(
	parameter W = 1
) (
	// clock, reset, enable
	input wire i_core_clk,
	input wire i_rst_b,
	input wire i_ce,
	// levels
	input wire [W-1:0] i_async,
	output reg [W-1:0] o_sync
);
	reg [W-1:0] meta_q;

	always @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			meta_q <= {W{1'b0}};
			o_sync <= {W{1'b0}};
		end else if (i_ce) begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end
endmodule

// >>> bfr_pause.v
// reconnection pause timer: busy while held and for PAUSE_CYCLES after release
// assumes the hold input is a level from the core clock domain
`include "bfr_defines.vh"
module bfr_pause #(
	parameter [63:0] PAUSE_CYCLES = `BFR_PAUSE_CYC
) (
	// clock, reset, enable
	input wire i_core_clk,
	input wire i_rst_b,
	input wire i_ce,
	// control
	input wire i_hold,
	output reg o_busy
);
	wire [31:0] load_w = PAUSE_CYCLES[31:0];
	reg [31:0] cnt_q;

	always @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			cnt_q <= 32'h00000000;
			o_busy <= 1'b0;
		end else if (i_ce) begin
			if (i_hold) begin
				cnt_q <= load_w;
				o_busy <= 1'b1;
			end else if (cnt_q > 32'h00000001) begin
				cnt_q <= cnt_q - 32'h00000001;
				o_busy <= 1'b1;
			end else begin
				cnt_q <= 32'h00000000;
				o_busy <= 1'b0;
			end
		end
	end
endmodule

// >>> pack_model.sv
// pack and inverter side: the current that flows for the present relay state
// assumes demand and leak levels are set by the bench
module pack_model #(
	parameter W = 16
) (
	// relay commands
	input wire i_chg_en,
	input wire i_dsg_en,
	input wire i_open_cmd,
	// bench levels
	input wire [W-1:0] i_demand,
	input wire [W-1:0] i_leak,
	// measured current
	output wire [W-1:0] o_current
);
	timeunit 1ns;
	timeprecision 1ps;
	// a welded contactor still passes the leak current once opened
	assign o_current = i_open_cmd ? i_leak : ((i_chg_en || i_dsg_en) ? i_demand : {W{1'b0}});
endmodule

// >>> bfr_chk.sv
// checker for the fault response outputs
// assumes the design's core clock and active-low reset
`include "bfr_defines.vh"
module bfr_chk #(
	parameter CUR_W = 16
) (
	// clock and reset
	input wire i_core_clk,
	input wire i_rst_b,
	input wire i_ce,
	// pins
	input wire [CUR_W-1:0] i_current,
	input wire i_contactor_open_cmd,
	input wire i_nvm_interrupted,
	input wire i_i2c_fail,
	input wire i_spi_fail,
	// outputs
	input wire o_charge_en,
	input wire o_discharge_en,
	input wire o_opto_relay_on,
	input wire o_charge_opto_en,
	input wire o_normal_run,
	input wire o_load_defaults,
	input wire [4:0] o_fault_code
);
	timeunit 1ns;
	timeprecision 1ps;
	wire blk = !o_charge_en && !o_discharge_en && !o_opto_relay_on;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);
	a_open_cur_trip:
	assert property ((i_ce && i_contactor_open_cmd && i_current != 0) [*4]
		|-> blk && o_fault_code == `BFR_CODE_11) else $error("open contactor fault missed");
	a_meas_blocks:
	assert property (o_fault_code == `BFR_CODE_12 |-> blk) else $error("fault 12 not blocking");
	a_pause_hold:
	assert property (o_fault_code == `BFR_CODE_12 ##1 o_fault_code != `BFR_CODE_12
		|-> (!o_charge_en) [*8]) else $error("reconnect without pause");
	a_cell_chemistry_select_blocks:
	assert property (o_fault_code == `BFR_CODE_13 |-> blk && !o_charge_opto_en)
		else $error("fault 13 outputs wrong");
	a_nvm_pulse:
	assert property ($rose(i_nvm_interrupted) ##1 i_nvm_interrupted [*2]
		|=> o_load_defaults ##1 !o_load_defaults) else $error("defaults pulse wrong");
	a_fuse_blocks:
	assert property (o_fault_code == `BFR_CODE_15 |-> blk) else $error("fault 15 not blocking");
	a_link_stop:
	assert property ((i_ce && (i_i2c_fail || i_spi_fail)) [*4] |-> blk && !o_normal_run)
		else $error("link fault not handled");
	a_over_keeps:
	assert property (o_fault_code == `BFR_CODE_17 |-> o_opto_relay_on)
		else $error("fault 17 opened relay");
	a_code_legal:
	assert property (o_fault_code == 5'h00
		|| (o_fault_code >= `BFR_CODE_11 && o_fault_code <= `BFR_CODE_17))
		else $error("illegal fault code");
endmodule
bind battery_fault_response bfr_chk #(.CUR_W(CUR_W)) bfr_chk_inst (.*);

// >>> tb.sv
// self-checking bench for battery_fault_response over its register port
// assumes a 250 MHz core clock and the pack model on the current input
`include "bfr_defines.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PC = 100;
	logic clk = 0, rst_b = 0, ce = 1, opn = 0, cell_chemistry_select = 1, nvm = 0;
	logic fuse = 0, bal = 0, done = 1, i2c = 0, spi = 0;
	logic awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0;
	logic [15:0] dem = 16'h0, leak = 16'h0;
	wire [15:0] cur, crep, drep;
	wire ce_o, de_o, rl, co, run, ldef, irq, awr, wr_o, bv, arr, rv;
	wire [4:0] code;
	wire [1:0] br, rr;
	wire [31:0] rdat;
	int err_total = 0, cmp_count = 0, cyc = 0;
	logic [7:0] ta [3] = '{`BFR_REG_SHUNT_MAX, `BFR_REG_CHG_TRIP, `BFR_REG_DSG_TRIP};
	logic [15:0] tv [3] = '{16'h0010, 16'h0100, 16'h0100};
	logic [15:0] td [3] = '{16'h0021, 16'h0101, 16'hFEFF};
	logic [15:0] od [3] = '{16'h0133, 16'h0134, 16'hFEC0};
	logic [4:0] oc [3] = '{5'h00, `BFR_CODE_17, `BFR_CODE_17};
	logic [15:0] orp [3] = '{16'h0100, 16'h0080, 16'h0080};

	pack_model #(.W(16)) pack_model_inst (.i_chg_en(ce_o), .i_dsg_en(de_o), .i_open_cmd(opn),
		.i_demand(dem), .i_leak(leak), .o_current(cur));
	battery_fault_response #(.PAUSE_CYCLES(PC)) battery_fault_response_inst (
		.i_core_clk(clk), .i_rst_b(rst_b), .i_ce(ce), .i_current(cur),
		.i_contactor_open_cmd(opn), .i_cell_chemistry_select_valid(cell_chemistry_select), .i_nvm_interrupted(nvm),
		.i_fuse_blown(fuse), .i_balance_fail(bal), .i_selfcheck_done(done),
		.i_i2c_fail(i2c), .i_spi_fail(spi), .o_charge_en(ce_o), .o_discharge_en(de_o),
		.o_opto_relay_on(rl), .o_charge_opto_en(co), .o_normal_run(run),
		.o_load_defaults(ldef), .o_chg_limit_rep(crep), .o_dsg_limit_rep(drep),
		.o_fault_code(code), .o_irq(irq), .i_awvalid(awv), .o_awready(awr), .i_awaddr(awa),
		.i_wvalid(wv), .o_wready(wr_o), .i_wdata(wd), .i_wstrb(4'hF), .o_bvalid(bv),
		.i_bready(bre), .o_bresp(br), .i_arvalid(arv), .o_arready(arr), .i_araddr(ara),
		.o_rvalid(rv), .i_rready(rre), .o_rdata(rdat), .o_rresp(rr));

	initial forever #2 clk = ~clk;

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			report_and_stop();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ha, hw;
		ha = 0;
		hw = 0;
		awv <= 1;
		awa <= a;
		wv <= 1;
		wd <= d;
		bre <= 1;
		while (!(ha && hw)) begin
			@(posedge clk);
			if (!ha && awr) begin
				ha = 1;
				awv <= 0;
			end
			if (!hw && wr_o) begin
				hw = 1;
				wv <= 0;
			end
		end
		do @(posedge clk); while (!bv);
		bre <= 0;
		chk(br, er);
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		arv <= 1;
		ara <= a;
		rre <= 1;
		do @(posedge clk); while (!arr);
		arv <= 0;
		do @(posedge clk); while (!rv);
		rre <= 0;
		chk(rdat, e);
		chk(rr, er);
		@(posedge clk);
	endtask

	task automatic rs();
		rst_b <= 0;
		wt(8);
		rst_b <= 1;
		wt(12);
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		rs();
		rd(`BFR_REG_CTRL, 32'h1, `BFR_RESP_OKAY);
		rd(`BFR_REG_MASK, 32'h0, `BFR_RESP_OKAY);
		for (int a = 16; a <= 32; a += 4) rd(a[7:0], 32'hFFFF, `BFR_RESP_OKAY);
		rd(8'h40, 32'h0, `BFR_RESP_SLVERR);
		wr(8'h40, 32'h1, `BFR_RESP_SLVERR);
		chk({code, ce_o, de_o, rl}, {5'h00, 3'h7});
		$display("end registers");
		dem <= 16'h0010;
		leak <= 16'h0005;
		for (int m = 1; m >= 0; m--) begin
			wr(`BFR_REG_MASK, m, `BFR_RESP_OKAY);
			opn <= 1;
			wt(6);
			chk({code, ce_o, de_o, rl}, {`BFR_CODE_11, 3'h0});
			chk(irq, m);
			rd(`BFR_REG_STATUS, 32'h1, `BFR_RESP_OKAY);
			opn <= 0;
			wt(6);
			wr(`BFR_REG_STATUS, 32'h1, `BFR_RESP_OKAY);
			wt(2);
			chk({irq, code, ce_o, de_o, rl}, {1'b0, 5'h00, 3'h7});
		end
		ce <= 0;
		opn <= 1;
		wt(6);
		chk({code, ce_o, de_o, rl}, {5'h00, 3'h7});
		ce <= 1;
		wt(6);
		chk({code, ce_o, de_o, rl}, {`BFR_CODE_11, 3'h0});
		opn <= 0;
		wt(6);
		$display("end stuck contactor");
		wr(`BFR_REG_CTRL, 32'h0, `BFR_RESP_OKAY);
		wt(6);
		chk({code, ce_o, de_o, rl}, {`BFR_CODE_12, 3'h0});
		wr(`BFR_REG_CTRL, 32'h1, `BFR_RESP_OKAY);
		wt(6);
		chk({code, ce_o, de_o, rl}, {5'h00, 3'h0});
		rd(`BFR_REG_FAULT, 32'h100, `BFR_RESP_OKAY);
		wt(PC);
		chk({ce_o, de_o, rl}, 3'h7);
		for (int k = 0; k < 3; k++) begin
			wr(`BFR_REG_STATUS, 32'h7F, `BFR_RESP_OKAY);
			wr(ta[k], {16'h0, tv[k]}, `BFR_RESP_OKAY);
			dem <= td[k];
			wt(6);
			rd(`BFR_REG_STATUS, 32'h2, `BFR_RESP_OKAY);
			chk({ce_o, de_o, rl}, 3'h0);
			dem <= 16'h0;
			wr(ta[k], 32'hFFFF, `BFR_RESP_OKAY);
			wt(PC + 10);
			chk({ce_o, de_o, rl}, 3'h7);
		end
		$display("end overcurrent trip");
		wr(`BFR_REG_CTRL, 32'h3, `BFR_RESP_OKAY);
		cell_chemistry_select <= 0;
		wt(6);
		chk({code, ce_o, de_o, rl, co}, {`BFR_CODE_13, 4'h0});
		cell_chemistry_select <= 1;
		wr(`BFR_REG_CTRL, 32'h1, `BFR_RESP_OKAY);
		nvm <= 1;
		wt(4);
		chk(ldef, 1'b1);
		wt(1);
		chk(ldef, 1'b0);
		wt(1);
		chk({code, ce_o, de_o, rl}, {`BFR_CODE_14, 3'h7});
		nvm <= 0;
		for (int k = 0; k < 2; k++) begin
			i2c <= (k == 0);
			spi <= (k == 1);
			wt(6);
			chk({code, ce_o, de_o, rl, run}, {`BFR_CODE_16, 4'h0});
			i2c <= 0;
			spi <= 0;
			wt(6);
			chk(run, 1'b1);
		end
		$display("end config and link");
		wr(`BFR_REG_CHG_LIM, 32'h0100, `BFR_RESP_OKAY);
		wr(`BFR_REG_DSG_LIM, 32'h0100, `BFR_RESP_OKAY);
		for (int k = 0; k < 3; k++) begin
			dem <= od[k];
			wt(6);
			chk({code, rl}, {oc[k], 1'b1});
			chk(od[k][15] ? drep : crep, orp[k]);
		end
		dem <= 16'h0;
		$display("end current limit");
		for (int k = 0; k < 2; k++) begin
			done <= 0;
			fuse <= (k == 0);
			bal <= (k == 1);
			rs();
			done <= 1;
			wt(6);
			fuse <= 0;
			bal <= 0;
			wt(6);
			chk({code, ce_o, de_o, rl}, {`BFR_CODE_15, 3'h0});
		end
		$display("end start-up check");
		report_and_stop();
	end
endmodule
